/* File: include/rail_fault_pkg.sv */
// Constants, types and register map of the rail fault sharing block
// What this block does
// - Shared alarm pin is only pulled low or released; pull-up makes high
// - Low on the shared alarm pin means fault, high means no fault
// - Alarm pin is both output (pull low) and input (sensed low)
// - Pin held low by another party shuts channels per response setting
// - Per-channel response enable turns channel off on shared fault
// - Per-channel propagate enable pulls the alarm pin low on local fault
// - After reset all response and propagate enables are set
// - Default enables: fault on any channel shuts down every channel
// - Propagate cleared: only the faulting channel turns off
// - Channel off by own fault turns back on after the retry period
// - Response cleared: channel stays on while others fault
// - Response and propagate are programmable per channel
package rail_fault_pkg;

    // Sizes
    localparam int NUM_CH  = 4;
    localparam int AW      = 8;
    localparam int RETRY_W = 16;

    // Register byte addresses
    localparam logic [AW-1:0] ADDR_CFG    = 8'h00;
    localparam logic [AW-1:0] ADDR_RUN    = 8'h04;
    localparam logic [AW-1:0] ADDR_RETRY  = 8'h08;
    localparam logic [AW-1:0] ADDR_STATUS = 8'h0c;
    localparam logic [AW-1:0] ADDR_FAULTS = 8'h10;

    // Field positions
    localparam int CFG_RESP_LSB  = 0;
    localparam int CFG_PROP_LSB  = 4;
    localparam int ST_EN_LSB     = 0;
    localparam int ST_OWN_LSB    = 4;
    localparam int ST_SHR_LSB    = 8;
    localparam int ST_LINE_BIT   = 12;
    localparam int ST_DRIVE_BIT  = 13;
    localparam int FLT_LOCAL_LSB = 0;
    localparam int FLT_EXT_BIT   = 4;

    // Reset values
    localparam logic [NUM_CH-1:0]  RESP_RST  = 4'hf;
    localparam logic [NUM_CH-1:0]  PROP_RST  = 4'hf;
    localparam logic [NUM_CH-1:0]  RUN_RST   = 4'hf;
    localparam logic [RETRY_W-1:0] RETRY_RST = 16'h0100;

    // Cycles the own-drive mask is stretched to cover the synchroniser
    localparam int MASK_LEN = 4;

    // APB request from the master
    typedef struct packed {
        logic          psel;
        logic          penable;
        logic          pwrite;
        logic [AW-1:0] paddr;
        logic [31:0]   pwdata;
    } apb_req_t;

endpackage

/* File: logic/fault_chan_cell.sv */
// One channel of the fault sharing logic: power state and retry timer
`timescale 1ns/1ps
module fault_chan_cell #(
    parameter int RW = 16
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // Configuration
    input  wire logic          run,
    input  wire logic          resp_en,
    input  wire logic          prop_en,
    input  wire logic [RW-1:0] retry_len,
    // Fault inputs
    input  wire logic          local_fault,
    input  wire logic          ext_fault,
    // State
    output logic               chan_on,
    output logic               own_off,
    output logic               shared_off,
    output logic               drive
);
    typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_OWN, ST_SHARED} chan_state_t;

    chan_state_t   state_r;
    chan_state_t   state_nxt;
    logic [RW-1:0] cnt_r;

    // Own fault has priority over a shared one
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (run) state_nxt = ST_ON;
            end
            ST_ON: begin
                if (!run) state_nxt = ST_IDLE;
                else if (local_fault) state_nxt = ST_OWN;
                else if (ext_fault && resp_en) state_nxt = ST_SHARED;
            end
            ST_OWN: begin
                if (!run) state_nxt = ST_IDLE;
                else if (cnt_r == '0) state_nxt = ST_ON;
            end
            ST_SHARED: begin
                if (!run) state_nxt = ST_IDLE;
                else if (local_fault) state_nxt = ST_OWN;
                else if (!ext_fault || !resp_en) state_nxt = ST_ON;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) state_r <= ST_IDLE;
        else         state_r <= state_nxt;
    end

    // Retry timer loads on entry to the own-fault state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
        end else if (state_r != ST_OWN && state_nxt == ST_OWN) begin
            cnt_r <= retry_len;
        end else if (state_r == ST_OWN && cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign chan_on    = (state_r == ST_ON);
    assign own_off    = (state_r == ST_OWN);
    assign shared_off = (state_r == ST_SHARED);
    assign drive      = own_off && prop_en;

    property p_retry_done;
        @(posedge clk) disable iff (!resetn)
        own_off && cnt_r == '0 && run |=> chan_on;
    endproperty
    a_retry_done: assert property (p_retry_done) else $error("no restart after retry");

    property p_own_trip;
        @(posedge clk) disable iff (!resetn)
        chan_on && run && local_fault |=> own_off && !shared_off;
    endproperty
    a_own_trip: assert property (p_own_trip) else $error("own fault not taken");

    property p_keep_alive;
        @(posedge clk) disable iff (!resetn)
        chan_on && run && !resp_en && !local_fault |=> chan_on;
    endproperty
    a_keep_alive: assert property (p_keep_alive) else $error("keep-alive rail shut");

    property p_shared_off;
        @(posedge clk) disable iff (!resetn)
        chan_on && run && resp_en && ext_fault && !local_fault |=> shared_off;
    endproperty
    a_shared_off: assert property (p_shared_off) else $error("no shared shutdown");

endmodule // fault_chan_cell

/* File: logic/rail_fault_sharing.sv */
// Top of the rail fault sharing block: APB registers, alarm pin, channels
`timescale 1ns/1ps
module rail_fault_sharing #(
    parameter int RW = rail_fault_pkg::RETRY_W
) (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              resetn,
    // APB slave
    input  wire rail_fault_pkg::apb_req_t          apb_req,
    output logic [31:0]                            prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // Local fault detection, same clock domain
    input  wire logic [rail_fault_pkg::NUM_CH-1:0] chan_fault,
    // Channel power enables
    output logic [rail_fault_pkg::NUM_CH-1:0]      chan_en,
    // Shared alarm pin, open drain, active low
    input  wire logic                              alarm_in,
    output logic                                   alarm_out,
    output logic                                   alarm_oe
);
    import rail_fault_pkg::*;

    logic [NUM_CH-1:0]   resp_en_r;
    logic [NUM_CH-1:0]   prop_en_r;
    logic [NUM_CH-1:0]   run_r;
    logic [RW-1:0]       retry_r;
    logic [NUM_CH-1:0]   flt_seen_r;
    logic                ext_seen_r;
    logic                alarm_meta_r;
    logic                alarm_sync_r;
    logic [MASK_LEN-1:0] drive_hist_r;

    logic [NUM_CH-1:0]   cell_on;
    logic [NUM_CH-1:0]   cell_own;
    logic [NUM_CH-1:0]   cell_shr;
    logic [NUM_CH-1:0]   cell_drive;
    logic [NUM_CH-1:0]   cell_ext;

    logic                acc;
    logic                commit;
    logic                wr_hit;
    logic                hit;
    logic [31:0]         rd_data;
    logic                line_low;
    logic                self_masked;
    logic                ext_line;
    logic [NUM_CH-1:0]   flt_clr;
    logic                ext_clr;

    // APB handshake: one wait state, so every answer comes from a flop
    assign acc    = apb_req.psel && apb_req.penable;
    assign commit = acc && pready;
    assign wr_hit = commit && apb_req.pwrite && hit;

    always_comb begin
        rd_data = 32'h0;
        hit     = 1'b1;
        if (apb_req.paddr == ADDR_CFG) begin
            rd_data[CFG_RESP_LSB +: NUM_CH] = resp_en_r;
            rd_data[CFG_PROP_LSB +: NUM_CH] = prop_en_r;
        end else if (apb_req.paddr == ADDR_RUN) begin
            rd_data[NUM_CH-1:0] = run_r;
        end else if (apb_req.paddr == ADDR_RETRY) begin
            rd_data[RW-1:0] = retry_r;
        end else if (apb_req.paddr == ADDR_STATUS) begin
            rd_data[ST_EN_LSB +: NUM_CH]  = chan_en;
            rd_data[ST_OWN_LSB +: NUM_CH] = cell_own;
            rd_data[ST_SHR_LSB +: NUM_CH] = cell_shr;
            rd_data[ST_LINE_BIT]          = line_low;
            rd_data[ST_DRIVE_BIT]         = alarm_oe;
        end else if (apb_req.paddr == ADDR_FAULTS) begin
            rd_data[FLT_LOCAL_LSB +: NUM_CH] = flt_seen_r;
            rd_data[FLT_EXT_BIT]             = ext_seen_r;
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (acc && !pready) begin
            pready  <= 1'b1;
            pslverr <= !hit;
            prdata  <= apb_req.pwrite ? 32'h0 : rd_data;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
    end

    // Configuration registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resp_en_r <= RESP_RST;
            prop_en_r <= PROP_RST;
        end else if (wr_hit && apb_req.paddr == ADDR_CFG) begin
            resp_en_r <= apb_req.pwdata[CFG_RESP_LSB +: NUM_CH];
            prop_en_r <= apb_req.pwdata[CFG_PROP_LSB +: NUM_CH];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_r <= RUN_RST;
        end else if (wr_hit && apb_req.paddr == ADDR_RUN) begin
            run_r <= apb_req.pwdata[NUM_CH-1:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            retry_r <= RW'(RETRY_RST);
        end else if (wr_hit && apb_req.paddr == ADDR_RETRY) begin
            retry_r <= apb_req.pwdata[RW-1:0];
        end
    end

    // Sticky fault record, write one to clear; a new event beats the clear
    assign flt_clr = (wr_hit && apb_req.paddr == ADDR_FAULTS) ?
                     apb_req.pwdata[FLT_LOCAL_LSB +: NUM_CH] : '0;
    assign ext_clr = wr_hit && apb_req.paddr == ADDR_FAULTS && apb_req.pwdata[FLT_EXT_BIT];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flt_seen_r <= '0;
            ext_seen_r <= 1'b0;
        end else begin
            flt_seen_r <= (flt_seen_r & ~flt_clr) | chan_fault;
            ext_seen_r <= (ext_seen_r && !ext_clr) || ext_line;
        end
    end

    // Alarm pin input: released level is high, so reset to high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alarm_meta_r <= 1'b1;
            alarm_sync_r <= 1'b1;
        end else begin
            alarm_meta_r <= alarm_in;
            alarm_sync_r <= alarm_meta_r;
        end
    end

    assign line_low = !alarm_sync_r;

    // While this device pulls the pin, a peer's pull cannot be told apart
    // from our own; the mask covers the drive flop plus the synchroniser.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) drive_hist_r <= '0;
        else         drive_hist_r <= {drive_hist_r[MASK_LEN-2:0], |cell_drive};
    end

    assign self_masked = (|cell_drive) || (|drive_hist_r);
    assign ext_line    = line_low && !self_masked;

    // Pin output: open drain, data fixed low, enable pulls the wire
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alarm_out <= 1'b0;
            alarm_oe  <= 1'b0;
        end else begin
            alarm_out <= 1'b0;
            alarm_oe  <= |cell_drive;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) chan_en <= '0;
        else         chan_en <= cell_on;
    end

    // Channels: a fault from a sibling is seen at once, a peer's via the pin
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        localparam logic [NUM_CH-1:0] SELF = NUM_CH'(1) << i;

        assign cell_ext[i] = (|(cell_drive & ~SELF)) || ext_line;

        fault_chan_cell #(
            .RW (RW)
        ) u_cell (
            .clk         (clk),
            .resetn      (resetn),
            .run         (run_r[i]),
            .resp_en     (resp_en_r[i]),
            .prop_en     (prop_en_r[i]),
            .retry_len   (retry_r),
            .local_fault (chan_fault[i]),
            .ext_fault   (cell_ext[i]),
            .chan_on     (cell_on[i]),
            .own_off     (cell_own[i]),
            .shared_off  (cell_shr[i]),
            .drive       (cell_drive[i])
        );
    end

    sequence s_cfg_write;
        acc && pready && apb_req.pwrite && apb_req.paddr == ADDR_CFG;
    endsequence

    property p_cfg_write;
        @(posedge clk) disable iff (!resetn)
        s_cfg_write |=> resp_en_r == $past(apb_req.pwdata[3:0])
                     && prop_en_r == $past(apb_req.pwdata[7:4]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("cfg write lost");

    property p_open_drain;
        @(posedge clk) disable iff (!resetn)
        alarm_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");

    property p_pull_on_fault;
        @(posedge clk) disable iff (!resetn)
        (|(cell_own & prop_en_r)) |=> alarm_oe;
    endproperty
    a_pull_on_fault: assert property (p_pull_on_fault) else $error("fault not broadcast");

    property p_no_pull_unprop;
        @(posedge clk) disable iff (!resetn)
        !(|(cell_own & prop_en_r)) |=> !alarm_oe;
    endproperty
    a_no_pull_unprop: assert property (p_no_pull_unprop) else $error("pin pulled spuriously");

    property p_sync_depth;
        @(posedge clk) disable iff (!resetn)
        $past(resetn, 2) && $past(resetn, 1) |-> alarm_sync_r == $past(alarm_in, 2);
    endproperty
    a_sync_depth: assert property (p_sync_depth) else $error("synchroniser depth wrong");

    sequence s_sibling_fault;
        (|cell_on) && (|(chan_fault & cell_on & prop_en_r)) && resp_en_r == RESP_RST
        && run_r == RUN_RST && !(|(chan_fault & ~(chan_fault & cell_on)));
    endsequence

    property p_all_down;
        @(posedge clk) disable iff (!resetn)
        s_sibling_fault ##1 (chan_fault == '0)[*2] |-> ##1 chan_en == '0;
    endproperty
    a_all_down: assert property (p_all_down) else $error("not all channels shut");

    property p_local_sticky;
        @(posedge clk) disable iff (!resetn)
        (|chan_fault) |=> (flt_seen_r & $past(chan_fault)) == $past(chan_fault);
    endproperty
    a_local_sticky: assert property (p_local_sticky) else $error("fault record lost");

    property p_en_follows;
        @(posedge clk) disable iff (!resetn)
        ##1 chan_en == $past(cell_on);
    endproperty
    a_en_follows: assert property (p_en_follows) else $error("enable lags state");

endmodule // rail_fault_sharing

/* File: sim/peer_manager.sv */
// Behavioural model of a peer power manager sharing the alarm line
`timescale 1ns/1ps
module peer_manager (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Bench command: pull the shared line
    input  wire logic pull_req,
    // Shared alarm pin, open drain
    input  wire logic alarm_in,
    output logic      alarm_out,
    output logic      alarm_oe,
    // Fault level as this peer reads it
    output logic      fault_seen
);
    // Only ever pulls low or lets go; the pull-up owns the high level
    assign alarm_out = 1'b0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alarm_oe <= 1'b0;
        end else begin
            alarm_oe <= pull_req;
        end
    end

    // Low means fault for every party on the line
    assign fault_seen = ~alarm_in;
endmodule // peer_manager

/* File: sim/testbench.sv */
// Self-checking bench for the rail fault sharing block
`timescale 1ns/1ps
module testbench;
    import rail_fault_pkg::*;

    logic              clk;
    logic              resetn;
    apb_req_t          req;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [NUM_CH-1:0] chan_fault;
    logic [NUM_CH-1:0] chan_en;
    logic              alarm_in;
    logic              alarm_out;
    logic              alarm_oe;
    logic              pull_req;
    logic              peer_out;
    logic              peer_oe;
    logic              peer_seen;
    logic [31:0]       rd;
    logic              err;
    int                mismatches;
    int                n_tests;

    rail_fault_sharing #(.RW(RETRY_W)) i_dut (
        .clk(clk), .resetn(resetn), .apb_req(req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_fault(chan_fault), .chan_en(chan_en),
        .alarm_in(alarm_in), .alarm_out(alarm_out), .alarm_oe(alarm_oe));

    peer_manager i_peer (
        .clk(clk), .resetn(resetn), .pull_req(pull_req), .alarm_in(alarm_in),
        .alarm_out(peer_out), .alarm_oe(peer_oe), .fault_seen(peer_seen));

    // Wired line with pull-up: a driving party shows its data, else released high
    assign alarm_in = (alarm_oe ? alarm_out : 1'b1) & (peer_oe ? peer_out : 1'b1);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            mismatches++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask

    // Pulse a local fault for one edge, then look three edges after it was taken
    task automatic fault(input int j);
        @(posedge clk);
        chan_fault <= 4'h1 << j;
        @(posedge clk);
        chan_fault <= 4'h0;
        repeat (3) @(posedge clk);
    endtask

    // Bounded wait for a given enable pattern; a timeout shows as a mismatch
    task automatic wait_en(input logic [3:0] e);
        for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            if (chan_en === e) break;
        end
        chk({28'h0, chan_en}, {28'h0, e});
        if (chan_en !== e) stop_test();
    endtask

    initial begin
        mismatches = 0;
        n_tests = 0;
        resetn = 1'b0;
        req = '0;
        chan_fault = 4'h0;
        pull_req = 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        // Register defaults and an unmapped place
        rd_chk(ADDR_CFG, 32'hffffffff, 32'h000000ff);
        rd_chk(ADDR_RUN, 32'hffffffff, 32'h0000000f);
        rd_chk(ADDR_RETRY, 32'hffffffff, 32'h00000100);
        rd_chk(ADDR_FAULTS, 32'hffffffff, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        wait_en(4'hf);
        chk({31'h0, alarm_oe}, 32'h0);
        // Short retry keeps the run brief
        apb(1'b1, ADDR_RETRY, 32'h4);
        // Default enables: one fault takes every rail down
        fault(3);
        chk({28'h0, chan_en}, 32'h0);
        chk({31'h0, alarm_oe}, 32'h1);
        chk({31'h0, alarm_out}, 32'h0);
        chk({31'h0, peer_seen}, 32'h1);
        wait_en(4'hf);
        rd_chk(ADDR_FAULTS, 32'hf, 32'h8);
        apb(1'b1, ADDR_FAULTS, 32'h1f);
        rd_chk(ADDR_FAULTS, 32'h1f, 32'h0);
        // Ch0 does not propagate, ch1 does not respond
        apb(1'b1, ADDR_CFG, 32'hed);
        fault(0);
        chk({28'h0, chan_en}, 32'he);
        chk({31'h0, alarm_oe}, 32'h0);
        wait_en(4'hf);
        fault(3);
        chk({28'h0, chan_en}, 32'h2);
        wait_en(4'hf);
        // Peer pulls the line; the synchroniser delays the response
        @(posedge clk);
        pull_req <= 1'b1;
        repeat (2) @(posedge clk);
        chk({28'h0, chan_en}, 32'hf);
        repeat (6) @(posedge clk);
        chk({28'h0, chan_en}, 32'h2);
        chk({31'h0, alarm_oe}, 32'h0);
        rd_chk(ADDR_STATUS, 32'h1000, 32'h1000);
        pull_req <= 1'b0;
        wait_en(4'hf);
        rd_chk(ADDR_FAULTS, 32'h10, 32'h10);
        apb(1'b1, ADDR_FAULTS, 32'h1f);
        // Each channel alone responds; neighbour faults
        for (int i = 0; i < NUM_CH; i++) begin
            apb(1'b1, ADDR_CFG, {24'h0, 4'hf, 4'h1 << i});
            fault((i + 1) % NUM_CH);
            chk({28'h0, chan_en}, {28'h0, ~((4'h1 << i) | (4'h1 << ((i + 1) % NUM_CH)))});
            wait_en(4'hf);
        end
        // Run request off drops every rail
        apb(1'b1, ADDR_RUN, 32'h0);
        wait_en(4'h0);
        apb(1'b1, ADDR_RUN, 32'hf);
        wait_en(4'hf);
        // Reset in mid-run restores every default
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        chk({28'h0, chan_en}, 32'h0);
        chk({31'h0, alarm_oe}, 32'h0);
        resetn <= 1'b1;
        rd_chk(ADDR_CFG, 32'hffffffff, 32'h000000ff);
        wait_en(4'hf);
        stop_test();
    end
endmodule // testbench
